// *** rtl/frp_cmd_unit.sv ***
// instruction unit: resume, power-down, release and identification reads
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - resume accepted only when suspended, not busy
// - resume clears suspend, engine raises busy
// - resume ignored if not suspended or busy
// - power loss drops suspend, resume then ignored
// - power-down only if select rises after bit8
// - in power-down only release instruction heard
// - powers up awake, never in power-down
// - release, select high, wake delay, then commands
// - ABh plus three dummies repeats device id
// - release/id ignored while busy
// - 90h address picks order, ids alternate
// - 92h address, mode, ids two bits per clock
// - 94h four lanes, four dummy clocks
// - 4Bh four dummies then 64-bit unique id
// - 9Fh gives maker, type, capacity bytes
// - suspend accepted when not suspended and busy
module frp_cmd_unit import frp_pkg::*; #(
	parameter logic [7:0] MFR_ID = 8'h5a, // arbitrary value
	parameter logic [7:0] DEV_ID = 8'h17, // arbitrary value
	parameter logic [7:0] MEM_TYPE = 8'h40, // arbitrary value
	parameter logic [7:0] CAPACITY = 8'h18, // arbitrary value
	parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// serial link pins
	input wire logic spi_cs_n,
	input wire logic spi_sck,
	input wire logic [3:0] spi_io_in,
	output logic [3:0] spi_io_out,
	output logic [3:0] spi_io_oe_n,
	// erase/program engine
	input wire logic busy_in,
	input wire logic power_fail,
	output logic suspend_flag,
	output logic suspend_req,
	output logic resume_req,
	output logic power_down
);
	localparam int A_ENTRY = 320;
	localparam int A_WAKE = 320;

	frp_pins_s pin_s1, pin_s2;
	logic sck_d, cs_d;
	frp_state_e state_r;
	frp_power_e pw_r;
	logic [5:0] cnt_r, tgt_r;
	logic [31:0] shift_r, shift_nxt;
	logic [7:0] cmd_r, cmd_w;
	logic [2:0] in_lanes_r, out_lanes_r;
	logic [63:0] out_r, pat_r, mfr_pat;
	logic [6:0] left_r, len_r;
	logic [3:0] io_out_r, io_oe_n_r;
	logic [11:0] pw_cnt_r;
	logic susp_r, sus_req_r, res_req_r, pd_r, swap;
	logic sck_rise, sck_fall, cs_rise, decode_w, exec_w, wake_go;

	// two-flop synchroniser; only stage two is looked at
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= PINS_IDLE;
			pin_s2 <= PINS_IDLE;
			sck_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			pin_s1 <= '{cs_n: spi_cs_n, sck: spi_sck, io: spi_io_in};
			pin_s2 <= pin_s1;
			sck_d <= pin_s2.sck;
			cs_d <= pin_s2.cs_n;
		end
	end

	// edges of the link clock and select
	assign sck_rise = pin_s2.sck && !sck_d && !pin_s2.cs_n;
	assign sck_fall = !pin_s2.sck && sck_d && !pin_s2.cs_n;
	assign cs_rise = pin_s2.cs_n && !cs_d;
	assign cmd_w = {shift_r[6:0], pin_s2.io[0]};
	assign decode_w = sck_rise && state_r == ST_CMD && cnt_r == CMD_BITS - 6'h01;
	// a frame that stopped right after the eighth bit
	assign exec_w = cs_rise && state_r == ST_END;
	assign wake_go = cs_rise && cmd_r == CMD_WAKE_ID && pw_r == PW_DOWN
		&& (state_r == ST_END || state_r == ST_DUMMY || state_r == ST_OUT);

	// input lanes: io0 alone, io1..0, or all four
	always_comb begin
		unique case (in_lanes_r)
			LANE4: shift_nxt = {shift_r[27:0], pin_s2.io};
			LANE2: shift_nxt = {shift_r[29:0], pin_s2.io[1:0]};
			default: shift_nxt = {shift_r[30:0], pin_s2.io[0]};
		endcase
		// lowest address bit picks which id leads
		swap = (cmd_r == CMD_MFR_ID) ? shift_nxt[0] : shift_nxt[8];
		mfr_pat = swap ? {4{DEV_ID, MFR_ID}} : {4{MFR_ID, DEV_ID}};
	end

	// instruction sequencer: sample on rising, drive on falling
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_CMD;
			cnt_r <= 6'h00;
			tgt_r <= 6'h00;
			shift_r <= 32'h0;
			cmd_r <= 8'h00;
			in_lanes_r <= LANE1;
			out_lanes_r <= LANE1;
			out_r <= 64'h0;
			pat_r <= 64'h0;
			left_r <= 7'h00;
			len_r <= 7'h00;
			io_out_r <= 4'h0;
			io_oe_n_r <= OE_NONE;
		end else if (pin_s2.cs_n) begin
			// select high ends any frame and frees the pins
			state_r <= ST_CMD;
			cnt_r <= 6'h00;
			in_lanes_r <= LANE1;
			io_oe_n_r <= OE_NONE;
		end else if (decode_w) begin
			cmd_r <= cmd_w;
			cnt_r <= 6'h00;
			shift_r <= shift_nxt;
			if (cmd_w == CMD_WAKE_ID && busy_in) begin
				state_r <= ST_IGNORE;
			end else if (pw_r != PW_ON && !(pw_r == PW_DOWN && cmd_w == CMD_WAKE_ID)) begin
				state_r <= ST_IGNORE;
			end else begin
				unique case (cmd_w)
					CMD_SUSPEND, CMD_RESUME, CMD_SLEEP: state_r <= ST_END;
					CMD_WAKE_ID: begin
						state_r <= ST_DUMMY;
						tgt_r <= DUMMY_ID_CLKS;
						pat_r <= {8{DEV_ID}};
						len_r <= LEN_DEV;
						out_lanes_r <= LANE1;
					end
					CMD_MFR_ID: begin
						state_r <= ST_ADDR;
						tgt_r <= ADDR1_CLKS;
					end
					CMD_MFR_ID2: begin
						state_r <= ST_ADDR;
						tgt_r <= ADDR2_CLKS;
						in_lanes_r <= LANE2;
					end
					CMD_MFR_ID4: begin
						state_r <= ST_ADDR;
						tgt_r <= ADDR4_CLKS;
						in_lanes_r <= LANE4;
					end
					CMD_UNIQUE: begin
						state_r <= ST_DUMMY;
						tgt_r <= DUMMY_UID_CLKS;
						pat_r <= UNIQUE_ID;
						len_r <= LEN_UID;
						out_lanes_r <= LANE1;
					end
					CMD_JEDEC: begin
						state_r <= ST_OUT;
						pat_r <= {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
						out_r <= {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
						len_r <= LEN_JEDEC;
						left_r <= LEN_JEDEC;
						out_lanes_r <= LANE1;
					end
					default: state_r <= ST_IGNORE;
				endcase
			end
		end else if (sck_rise) begin
			unique case (state_r)
				ST_CMD: begin
					shift_r <= shift_nxt;
					cnt_r <= cnt_r + 6'h01;
				end
				ST_ADDR: begin
					shift_r <= shift_nxt;
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == tgt_r - 6'h01) begin
						cnt_r <= 6'h00;
						pat_r <= mfr_pat;
						out_r <= mfr_pat;
						len_r <= LEN_MFR_DEV;
						left_r <= LEN_MFR_DEV;
						out_lanes_r <= in_lanes_r;
						// mode byte is taken but not acted on
						if (cmd_r == CMD_MFR_ID4) begin
							state_r <= ST_DUMMY;
							tgt_r <= DUMMY_QUAD_CLKS;
						end else begin
							state_r <= ST_OUT;
						end
					end
				end
				ST_DUMMY: begin
					cnt_r <= cnt_r + 6'h01;
					if (cnt_r == tgt_r - 6'h01) begin
						state_r <= ST_OUT;
						out_r <= pat_r;
						left_r <= len_r;
					end
				end
				ST_END: state_r <= ST_IGNORE;
				ST_OUT, ST_IGNORE: state_r <= state_r;
			endcase
		end else if (sck_fall && state_r == ST_OUT) begin
			// msb first on the top lanes; pattern restarts until select rises
			unique case (out_lanes_r)
				LANE4: begin
					io_out_r <= out_r[63:60];
					io_oe_n_r <= OE_QUAD;
				end
				LANE2: begin
					io_out_r <= {2'b00, out_r[63:62]};
					io_oe_n_r <= OE_DUAL;
				end
				default: begin
					io_out_r <= {2'b00, out_r[63], 1'b0};
					io_oe_n_r <= OE_SINGLE;
				end
			endcase
			if (left_r == {4'h0, out_lanes_r}) begin
				out_r <= pat_r;
				left_r <= len_r;
			end else begin
				out_r <= out_r << out_lanes_r;
				left_r <= left_r - {4'h0, out_lanes_r};
			end
		end
	end

	// suspend flag and engine handshakes; an accepted suspend wins over power loss
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			susp_r <= 1'b0;
			sus_req_r <= 1'b0;
			res_req_r <= 1'b0;
		end else begin
			sus_req_r <= 1'b0;
			res_req_r <= 1'b0;
			if (exec_w && cmd_r == CMD_SUSPEND && !susp_r && busy_in) begin
				susp_r <= 1'b1;
				sus_req_r <= 1'b1;
			end else if (exec_w && cmd_r == CMD_RESUME && susp_r && !busy_in) begin
				// engine must raise busy within its own bound
				susp_r <= 1'b0;
				res_req_r <= 1'b1;
			end else if (power_fail) begin
				susp_r <= 1'b0;
			end
		end
	end

	// power state: entry delay, sleep, wake delay
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pw_r <= PW_ON;
			pd_r <= 1'b0;
			pw_cnt_r <= 12'h000;
		end else begin
			unique case (pw_r)
				PW_ON: if (exec_w && cmd_r == CMD_SLEEP) begin
					pw_r <= PW_ENTERING;
					pw_cnt_r <= SLEEP_ENTRY_CYC - 12'h001;
				end
				PW_ENTERING: if (pw_cnt_r == 12'h000) begin
					pw_r <= PW_DOWN;
					pd_r <= 1'b1;
				end else begin
					pw_cnt_r <= pw_cnt_r - 12'h001;
				end
				// a bare release is still at dummy count zero and waits the full delay
				PW_DOWN: if (wake_go) begin
					pw_r <= PW_WAKING;
					pw_cnt_r <= (state_r == ST_DUMMY && cnt_r == 6'h00) ? WAKE_CYC - 12'h001
						: WAKE_ID_CYC - 12'h001;
				end
				PW_WAKING: if (pw_cnt_r == 12'h000) begin
					pw_r <= PW_ON;
					pd_r <= 1'b0;
				end else begin
					pw_cnt_r <= pw_cnt_r - 12'h001;
				end
			endcase
		end
	end

	assign spi_io_out = io_out_r;
	assign spi_io_oe_n = io_oe_n_r;
	assign suspend_flag = susp_r;
	assign suspend_req = sus_req_r;
	assign resume_req = res_req_r;
	assign power_down = pd_r;

	sequence s_sleep_go;
		exec_w && cmd_r == CMD_SLEEP && pw_r == PW_ON;
	endsequence
	sequence s_asleep;
		!power_down ##[1:A_ENTRY] power_down;
	endsequence

	a_resume_accept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		exec_w && cmd_r == CMD_RESUME && susp_r && !busy_in |=> !suspend_flag && resume_req)
		else $error("resume not taken");
	a_resume_ignore: assert property (@(posedge sys_clk) disable iff (!rst_n)
		exec_w && cmd_r == CMD_RESUME && (!susp_r || busy_in) |=> !resume_req)
		else $error("resume taken wrongly");
	a_power_loss: assert property (@(posedge sys_clk) disable iff (!rst_n)
		power_fail && !(exec_w && cmd_r == CMD_SUSPEND) |=> !suspend_flag)
		else $error("suspend kept after power loss");
	a_suspend_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		exec_w && cmd_r == CMD_SUSPEND && !susp_r && busy_in |=> suspend_flag && suspend_req)
		else $error("suspend not taken");
	a_sleep_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_sleep_go |=> s_asleep)
		else $error("power-down not entered");
	a_sleep_exact: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cs_rise && state_r != ST_END && pw_r == PW_ON |=> pw_r == PW_ON)
		else $error("power-down without clean frame");
	a_sleep_deaf: assert property (@(posedge sys_clk) disable iff (!rst_n)
		decode_w && pw_r == PW_DOWN && cmd_w != CMD_WAKE_ID |=> state_r == ST_IGNORE)
		else $error("instruction heard in power-down");
	a_wake_delay: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wake_go |=> power_down [*8] ##[1:A_WAKE] !power_down)
		else $error("wake delay wrong");
	a_busy_noid: assert property (@(posedge sys_clk) disable iff (!rst_n)
		decode_w && cmd_w == CMD_WAKE_ID && busy_in |=> state_r == ST_IGNORE && $stable(pw_r))
		else $error("release heard while busy");
	a_powerup_awake: assert property (@(posedge sys_clk)
		$rose(rst_n) |-> !power_down)
		else $error("came up in power-down");
	a_drive_fall: assert property (@(posedge sys_clk) disable iff (!rst_n)
		sck_fall && state_r == ST_OUT |=> spi_io_oe_n != OE_NONE)
		else $error("no drive after falling edge");
endmodule : frp_cmd_unit
`default_nettype wire

// *** rtl/frp_pkg.sv ***
// constants, types and timing for the flash resume / power-down / id instruction unit
package frp_pkg;
	// instruction codes
	localparam logic [7:0] CMD_SUSPEND = 8'h75;
	localparam logic [7:0] CMD_RESUME = 8'h7a;
	localparam logic [7:0] CMD_SLEEP = 8'hb9;
	localparam logic [7:0] CMD_WAKE_ID = 8'hab;
	localparam logic [7:0] CMD_MFR_ID = 8'h90;
	localparam logic [7:0] CMD_MFR_ID2 = 8'h92;
	localparam logic [7:0] CMD_MFR_ID4 = 8'h94;
	localparam logic [7:0] CMD_UNIQUE = 8'h4b;
	localparam logic [7:0] CMD_JEDEC = 8'h9f;
	// clocks per phase (serial clocks)
	localparam logic [5:0] CMD_BITS = 6'h08;
	localparam logic [5:0] ADDR1_CLKS = 6'h18;
	localparam logic [5:0] ADDR2_CLKS = 6'h10;
	localparam logic [5:0] ADDR4_CLKS = 6'h08;
	localparam logic [5:0] DUMMY_ID_CLKS = 6'h18;
	localparam logic [5:0] DUMMY_UID_CLKS = 6'h20;
	localparam logic [5:0] DUMMY_QUAD_CLKS = 6'h04;
	// output pattern lengths in bits
	localparam logic [6:0] LEN_DEV = 7'h08;
	localparam logic [6:0] LEN_MFR_DEV = 7'h10;
	localparam logic [6:0] LEN_JEDEC = 7'h18;
	localparam logic [6:0] LEN_UID = 7'h40;
	// lane widths
	localparam logic [2:0] LANE1 = 3'h1;
	localparam logic [2:0] LANE2 = 3'h2;
	localparam logic [2:0] LANE4 = 3'h4;
	// drive enables, low while driving
	localparam logic [3:0] OE_NONE = 4'hf;
	localparam logic [3:0] OE_SINGLE = 4'hd;
	localparam logic [3:0] OE_DUAL = 4'hc;
	localparam logic [3:0] OE_QUAD = 4'h0;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int RESUME_BUSY_NS = 200;
	localparam int SLEEP_ENTRY_NS = 3000;
	localparam int WAKE_NS = 3000;
	localparam int WAKE_ID_NS = 1800;
	localparam int RESUME_BUSY_CYC = RESUME_BUSY_NS * CLK_MHZ / 1000;
	localparam logic [11:0] SLEEP_ENTRY_CYC = 12'((SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] WAKE_CYC = 12'((WAKE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [11:0] WAKE_ID_CYC = 12'((WAKE_ID_NS * CLK_MHZ + 999) / 1000);

	// serial pins after synchronisation
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic [3:0] io;
	} frp_pins_s;
	localparam frp_pins_s PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, io: 4'h0};

	typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_OUT, ST_END, ST_IGNORE} frp_state_e;
	typedef enum {PW_ON, PW_ENTERING, PW_DOWN, PW_WAKING} frp_power_e;
endpackage : frp_pkg

// *** test/frp_cmd_unit_tb.sv ***
// self-checking bench for the resume, power-down and id instruction unit
`timescale 1ns/100ps
`default_nettype none
module frp_cmd_unit_tb import frp_pkg::*;;
	localparam logic [7:0] MFR = 8'hc3; // arbitrary value
	localparam logic [7:0] DEV = 8'h2e; // arbitrary value
	localparam logic [7:0] TYP = 8'h61; // arbitrary value
	localparam logic [7:0] CAP = 8'h19; // arbitrary value
	localparam logic [63:0] UID = 64'hfeed_0123_beef_4567; // arbitrary value
	logic sys_clk, rst_n, cs_n, sck, busy_in, power_fail;
	logic suspend_flag, suspend_req, resume_req, power_down;
	logic [3:0] io_in, io_out, oe_n;
	logic [63:0] r, av;
	int seed = 44321;
	int num_errors = 0;
	int n_compared = 0;
	int n_sus = 0;
	int n_res = 0;
	int n_drv = 0;
	int d0, cyc = 0;

	frp_cmd_unit #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP),
		.UNIQUE_ID(UID)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .spi_cs_n(cs_n),
		.spi_sck(sck), .spi_io_in(io_in), .spi_io_out(io_out), .spi_io_oe_n(oe_n),
		.busy_in(busy_in), .power_fail(power_fail), .suspend_flag(suspend_flag),
		.suspend_req(suspend_req), .resume_req(resume_req), .power_down(power_down));
	frp_host_model h (.sys_clk(sys_clk), .spi_cs_n(cs_n), .spi_sck(sck),
		.spi_io_in(io_in), .spi_io_out(io_out), .spi_io_oe_n(oe_n));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;
	// count engine pulses and cycles where the device drives a lane, sampled when settled
	always @(negedge sys_clk) begin
		if (suspend_req === 1'b1) n_sus++;
		if (resume_req === 1'b1) n_res++;
		if (oe_n !== OE_NONE) n_drv++;
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			results();
		end
	end

	function automatic logic [63:0] rnd();
		return {$random(seed), $random(seed)};
	endfunction : rnd
	// id pair order picked by address bit 0, repeated
	function automatic logic [63:0] pair(input int a);
		return a ? 64'({2{DEV, MFR}}) : 64'({2{MFR, DEV}});
	endfunction : pair

	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic results();
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// main sequence: ids, suspend/resume, power-down
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		busy_in = 1'b0;
		power_fail = 1'b0;
		repeat (8) @(negedge sys_clk);
		rst_n = 1'b1;
		chk("power_down", 0, 64'(power_down));
		repeat (4) @(negedge sys_clk);
		h.frame(CMD_JEDEC, 0, 0, 1, 0, 0, 48, 1, r);
		chk("jedec", 64'({2{MFR, TYP, CAP}}), r);
		h.frame(CMD_WAKE_ID, 0, 0, 1, rnd(), 24, 16, 1, r);
		chk("dev_id", 64'({2{DEV}}), r);
		h.frame(CMD_UNIQUE, 0, 0, 1, rnd(), 32, 64, 1, r);
		chk("unique", UID, r);
		for (int a = 0; a < 2; a++) begin
			av = {32'h0, 23'h0, 1'(a), 4'hf, 4'($random(seed))}; // mode byte Fx
			h.frame(CMD_MFR_ID, av >> 8, 24, 1, 0, 0, 32, 1, r);
			chk("mfr_dev1", pair(a), r);
			h.frame(CMD_MFR_ID2, av, 16, 2, 0, 0, 16, 2, r);
			chk("mfr_dev2", pair(a), r);
			h.frame(CMD_MFR_ID4, av, 8, 4, rnd(), 4, 8, 4, r);
			chk("mfr_dev4", pair(a), r);
		end
		busy_in = 1'b1;
		h.frame(CMD_SUSPEND, 0, 0, 1, 0, 0, 0, 1, r);
		chk("suspend_flag", 1, 64'(suspend_flag));
		chk("suspend_req", 1, 64'(n_sus));
		h.frame(CMD_RESUME, 0, 0, 1, 0, 0, 0, 1, r);
		chk("resume_busy", 0, 64'(n_res));
		busy_in = 1'b0;
		h.frame(CMD_RESUME, 0, 0, 1, 0, 0, 0, 1, r);
		chk("resume_req", 1, 64'(n_res));
		chk("resume_flag", 0, 64'(suspend_flag));
		h.frame(CMD_RESUME, 0, 0, 1, 0, 0, 0, 1, r);
		chk("resume_idle", 1, 64'(n_res));
		busy_in = 1'b1;
		repeat (30) @(negedge sys_clk); // suspend latency after resume
		h.frame(CMD_SUSPEND, 0, 0, 1, 0, 0, 0, 1, r);
		busy_in = 1'b0;
		power_fail = 1'b1;
		@(negedge sys_clk);
		power_fail = 1'b0;
		@(negedge sys_clk);
		chk("fail_flag", 0, 64'(suspend_flag));
		h.frame(CMD_RESUME, 0, 0, 1, 0, 0, 0, 1, r);
		chk("resume_lost", 1, 64'(n_res));
		// a ninth clock spoils the sleep instruction
		h.frame(CMD_SLEEP, rnd(), 1, 1, 0, 0, 0, 1, r);
		repeat (310) @(negedge sys_clk);
		chk("sleep_long", 0, 64'(power_down));
		h.frame(CMD_SLEEP, 0, 0, 1, 0, 0, 0, 1, r);
		repeat (310) @(negedge sys_clk);
		chk("sleep", 1, 64'(power_down));
		d0 = n_drv;
		h.frame(CMD_JEDEC, 0, 0, 1, 0, 0, 24, 1, r);
		chk("asleep_quiet", 64'(d0), 64'(n_drv));
		busy_in = 1'b1;
		h.frame(CMD_WAKE_ID, 0, 0, 1, 0, 0, 0, 1, r);
		busy_in = 1'b0;
		repeat (310) @(negedge sys_clk);
		chk("wake_busy", 1, 64'(power_down));
		h.frame(CMD_WAKE_ID, 0, 0, 1, 0, 0, 0, 1, r);
		chk("waking", 1, 64'(power_down));
		repeat (200) @(negedge sys_clk); // a bare release waits the full wake delay
		chk("wake_long", 1, 64'(power_down));
		repeat (110) @(negedge sys_clk); // select held high over the wake delay
		chk("awake", 0, 64'(power_down));
		h.frame(CMD_JEDEC, 0, 0, 1, 0, 0, 24, 1, r);
		chk("jedec_awake", 64'({MFR, TYP, CAP}), r);
		// sleep again, then leave through the id-reading form
		h.frame(CMD_SLEEP, 0, 0, 1, 0, 0, 0, 1, r);
		repeat (310) @(negedge sys_clk);
		h.frame(CMD_WAKE_ID, 0, 0, 1, rnd(), 24, 8, 1, r);
		chk("wake_id", 64'(DEV), r);
		repeat (180) @(negedge sys_clk); // select high over the id wake delay
		chk("awake_id", 0, 64'(power_down));
		results();
	end
endmodule : frp_cmd_unit_tb
`default_nettype wire

// *** test/frp_host_model.sv ***
// host side of the serial link: select, clock and data lanes
`timescale 1ns/100ps
`default_nettype none
module frp_host_model (
	// system clock, used only to pace the link
	input wire logic sys_clk,
	// link pins
	output logic spi_cs_n,
	output logic spi_sck,
	output logic [3:0] spi_io_in,
	input wire logic [3:0] spi_io_out,
	input wire logic [3:0] spi_io_oe_n
);
	logic [3:0] drv_r;
	logic [3:0] drv_m;
	logic [3:0] idle_r = 4'h5;

	initial begin
		spi_cs_n = 1'b1;
		spi_sck = 1'b0;
		drv_r = 4'h0;
		drv_m = 4'h0;
	end
	// undriven lanes toggle so a stale bit never passes for data
	always @(negedge sys_clk) begin
		idle_r <= ~idle_r;
	end
	// wire level from both parties' enables
	assign spi_io_in = (~spi_io_oe_n & spi_io_out) |
		(spi_io_oe_n & ((drv_m & drv_r) | (~drv_m & idle_r)));

	// half a serial clock: 80 ns
	task automatic half();
		repeat (8) @(negedge sys_clk);
	endtask : half

	// lanes change while sck is low, read bits taken at the rise
	task automatic xfer(input logic [63:0] v, input int n, input int w, input logic [3:0] m,
		output logic [63:0] r);
		r = '0;
		for (int k = 0; k < n; k++) begin
			drv_r = 4'(v >> (w * (n - 1 - k)));
			drv_m = m;
			half();
			spi_sck = 1'b1;
			r = (r << w) | 64'(w == 1 ? 4'(spi_io_in[1]) : spi_io_in & 4'((1 << w) - 1));
			half();
			spi_sck = 1'b0;
		end
	endtask : xfer

	// whole frame: code, address, dummies, read-back, then select high
	task automatic frame(input logic [7:0] c, input logic [63:0] a, input int na, input int wa,
		input logic [63:0] d, input int nd, input int nr, input int wr, output logic [63:0] r);
		logic [3:0] m;
		m = 4'((1 << wa) - 1);
		spi_cs_n = 1'b0;
		half();
		xfer(64'(c), 8, 1, 4'h1, r);
		xfer(a, na, wa, m, r);
		xfer(d, nd, wa, m, r);
		xfer('0, nr, wr, 4'h0, r);
		spi_cs_n = 1'b1; // select rises right after the last bit
		drv_m = 4'h0;
		half(); // gap well over 3 cycles between frames
	endtask : frame
endmodule : frp_host_model
`default_nettype wire
